// ---- bebf_map.vh ----
/*
 file holds the constants of the demag / zero-crossing blanking and event filter:
 field widths, reset values and window timing in microseconds and clock cycles.
 assumes the including module runs on a 25 MHz system clock.
*/
`ifndef BEBF_MAP_VH
`define BEBF_MAP_VH

// clock rate in kHz, used to turn microseconds into cycles
`define BEBF_CLK_KHZ 25000
// window step sizes in microseconds, short and long halves of the code space
`define BEBF_STEP_SHORT_US 5
`define BEBF_STEP_LONG_US 20
// first long-range code starts at 60 us
`define BEBF_LONG_BASE_US 60
// cycles per microsecond at the system clock (25 MHz gives 25)
`define BEBF_CYC_PER_US (`BEBF_CLK_KHZ / 1000)
// reset value of both window fields: code 15, i.e. 200 us
`define BEBF_BLANK_RST 4'hF
// reset value of both count fields: code 0, i.e. limit of one
`define BEBF_LIMIT_RST 4'h0
// counter width for window lengths (200 us * 25 = 5000 cycles)
`define BEBF_WIN_W 13

`endif

// ---- bebf_filter.v ----
/*
 file holds the blanking-window and consecutive-event filter that qualifies
 demagnetization (d) and zero-crossing (z) events from the sampled phase comparator.
 assumes the comparator output is asynchronous (synchronised here), that the
 sampling tick, commutation and simulated events come from logic on sys_clk_i,
 and that configuration ports are held steady by the control logic.
*/
// Notes on behaviour
// - sensorless: demag blanking window after each commutation
// - window starts after hardware and software commutations
// - after window, count consecutive demag detections
// - demag flag when count reaches field plus one
// - simulated demag bypasses count, limit is one
// - sensor mode: no demag window, no count filter
// - window codes 5-40us step 5, 60-200us step 20
// - sensorless: zero-cross window after each demag event
// - zero-cross window after hardware and software demag
// - after window, count consecutive zero-cross detections
// - zero-cross flag when count reaches field plus one
// - simulated zero-cross limit one; filter active in sensor mode
// - events set sticky flags, masked onto interrupt request
// - edge protect ignores count, needs true transition
`include "bebf_map.vh"
`timescale 1ns/1ps
`default_nettype none

module bebf_filter #(
   parameter CNT_W = 4 // width of the consecutive counters
) (
   input wire sys_clk_i, // 25 MHz system clock
   input wire resetn_i, // asynchronous active-low reset
   input wire comp_i, // raw phase comparator output, asynchronous
   input wire sample_tick_i, // one-cycle sampling_frequency tick
   input wire commutate_i, // commutation event pulse, hw or sw
   input wire sim_demag_i, // simulated demag event pulse
   input wire sim_zero_cross_i, // simulated zero-crossing pulse
   input wire sensor_mode_select_i, // 1 = position-sensor mode
   input wire edge_relation_select_i, // 1 = d and z use the same edge
   input wire comparator_edge_select_i, // 1 = z on rising edge, d on falling unless relation bit set
   input wire edge_protect_enable_i, // z needs a real transition
   input wire [3:0] demag_blank_len_i, // demag window code
   input wire [3:0] demag_count_limit_i, // demag limit minus one
   input wire [3:0] zero_cross_blank_len_i, // zero-cross window code
   input wire [3:0] zero_cross_count_limit_i, // zero-cross limit minus one
   input wire demag_irq_mask_i, // demag interrupt mask
   input wire zero_cross_irq_mask_i, // zero-cross interrupt mask
   input wire demag_irq_clr_i, // clear demag flag pulse
   input wire zero_cross_irq_clr_i, // clear zero-cross flag pulse
   output reg demag_event_o, // qualified demag event pulse
   output reg zero_cross_event_o, // qualified zero-cross event pulse
   output reg demag_irq_flag_o, // sticky demag flag
   output reg zero_cross_irq_flag_o, // sticky zero-cross flag
   output reg irq_o, // interrupt request
   output reg demag_blank_o, // demag window open
   output reg zero_cross_blank_o // zero-cross window open
);

   // phase states: idle, waiting for d or waiting for z
   localparam [2:0] ST_IDLE = 3'b001; // nothing armed yet
   localparam [2:0] ST_DEMAG = 3'b010; // after c, looking for d
   localparam [2:0] ST_ZERO = 3'b100; // after d, looking for z

   reg comp_meta_q; // first synchroniser stage, read only by comp_sync_q
   reg comp_sync_q; // synchronised comparator
   reg prev_samp_q; // comparator level at the previous tick
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [`BEBF_WIN_W-1:0] win_q; // blanking countdown
   reg [`BEBF_WIN_W-1:0] win_d;
   reg [CNT_W-1:0] cnt_q; // consecutive matches so far
   reg [CNT_W-1:0] cnt_d;
   reg d_hit; // qualified demag this cycle
   reg z_hit; // qualified zero-cross this cycle
   reg lvl_d; // comparator level expected at end of demag
   reg lvl_z; // comparator level expected at zero crossing
   reg match; // current sample equals expected level
   reg [`BEBF_WIN_W-1:0] d_len; // demag window in cycles
   reg [`BEBF_WIN_W-1:0] z_len; // zero-cross window in cycles

   // converts a window code to cycles; short codes step 5 us, long ones 20 us
   function [`BEBF_WIN_W-1:0] win_cycles;
      input [3:0] code;
      reg [31:0] us;
      reg [31:0] cyc_n;
      begin
         us = 32'h0000_0000;
         if (code[3] == 1'b0) begin
            us = `BEBF_STEP_SHORT_US * ({28'h000_0000, code} + 32'h0000_0001);
         end else begin
            us = `BEBF_LONG_BASE_US + `BEBF_STEP_LONG_US * {29'h0000_0000, code[2:0]};
         end
         cyc_n = us * `BEBF_CYC_PER_US;
         // the longest code gives 5000 cycles, so the dropped top bits are always zero
         win_cycles = cyc_n[`BEBF_WIN_W-1:0];
      end
   endfunction

   // two-flop synchroniser for the asynchronous comparator
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         comp_meta_q <= 1'b0;
         comp_sync_q <= 1'b0;
      end else begin
         comp_meta_q <= comp_i;
         comp_sync_q <= comp_meta_q;
      end
   end

   // combinational filter; window and count share one counter pair since
   // only one of d or z is being searched for at any time
   always @* begin
      state_d = state_q;
      win_d = win_q;
      cnt_d = cnt_q;
      d_hit = 1'b0;
      z_hit = 1'b0;
      d_len = win_cycles(demag_blank_len_i);
      z_len = win_cycles(zero_cross_blank_len_i);
      // d looks for the edge opposite to z unless the relation bit is set
      lvl_z = comparator_edge_select_i;
      lvl_d = edge_relation_select_i ? comparator_edge_select_i : ~comparator_edge_select_i;
      match = 1'b0;
      if (win_q != {`BEBF_WIN_W{1'b0}}) begin
         win_d = win_q - {{(`BEBF_WIN_W-1){1'b0}}, 1'b1};
      end
      case (state_q)
         ST_DEMAG: begin
            match = (comp_sync_q == lvl_d);
            if (sim_demag_i) begin
               d_hit = 1'b1;
            end else if (sample_tick_i && win_q == {`BEBF_WIN_W{1'b0}}) begin
               if (!match) begin
                  cnt_d = {CNT_W{1'b0}};
               end else if (sensor_mode_select_i || cnt_q == demag_count_limit_i) begin
                  d_hit = 1'b1;
               end else begin
                  cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
         end
         ST_ZERO: begin
            match = (comp_sync_q == lvl_z);
            if (sim_zero_cross_i) begin
               z_hit = 1'b1;
            end else if (sample_tick_i && win_q == {`BEBF_WIN_W{1'b0}}) begin
               if (!match) begin
                  cnt_d = {CNT_W{1'b0}};
               end else if (edge_protect_enable_i) begin
                  z_hit = (prev_samp_q != comp_sync_q);
               end else if (cnt_q == zero_cross_count_limit_i) begin
                  z_hit = 1'b1;
               end else begin
                  cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (d_hit) begin
         state_d = ST_ZERO;
         cnt_d = {CNT_W{1'b0}};
         win_d = sensor_mode_select_i ? {`BEBF_WIN_W{1'b0}} : z_len;
      end
      if (z_hit) begin
         state_d = ST_IDLE;
         cnt_d = {CNT_W{1'b0}};
      end
      // commutation restarts the search whatever else happened
      if (commutate_i) begin
         state_d = ST_DEMAG;
         cnt_d = {CNT_W{1'b0}};
         win_d = sensor_mode_select_i ? {`BEBF_WIN_W{1'b0}} : d_len;
      end
   end

   // state registers, events and sticky flags
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         win_q <= {`BEBF_WIN_W{1'b0}};
         cnt_q <= {CNT_W{1'b0}};
         prev_samp_q <= 1'b0;
         demag_event_o <= 1'b0;
         zero_cross_event_o <= 1'b0;
         demag_irq_flag_o <= 1'b0;
         zero_cross_irq_flag_o <= 1'b0;
         irq_o <= 1'b0;
         demag_blank_o <= 1'b0;
         zero_cross_blank_o <= 1'b0;
      end else begin
         state_q <= state_d;
         win_q <= win_d;
         cnt_q <= cnt_d;
         if (sample_tick_i) begin
            prev_samp_q <= comp_sync_q;
         end
         demag_event_o <= d_hit;
         zero_cross_event_o <= z_hit;
         // set wins over a clear in the same cycle
         if (d_hit) begin
            demag_irq_flag_o <= 1'b1;
         end else if (demag_irq_clr_i) begin
            demag_irq_flag_o <= 1'b0;
         end
         if (z_hit) begin
            zero_cross_irq_flag_o <= 1'b1;
         end else if (zero_cross_irq_clr_i) begin
            zero_cross_irq_flag_o <= 1'b0;
         end
         irq_o <= ((d_hit | (demag_irq_flag_o & ~demag_irq_clr_i)) & demag_irq_mask_i)
            | ((z_hit | (zero_cross_irq_flag_o & ~zero_cross_irq_clr_i))
            & zero_cross_irq_mask_i);
         demag_blank_o <= (state_d == ST_DEMAG) && (win_d != {`BEBF_WIN_W{1'b0}});
         zero_cross_blank_o <= (state_d == ST_ZERO) && (win_d != {`BEBF_WIN_W{1'b0}});
      end
   end

endmodule

`default_nettype wire

// ---- bebf_phase_src.sv ----
/* phase comparator stand-in for the filter bench.
   assumes the bench sets the winding level; the output is asynchronous. */
`timescale 1ns/1ps
`default_nettype none
module bebf_phase_src #(
   parameter int DLY = 7 // lag after the level change, off the clock edge
) (
   input wire logic level_i, // winding above threshold
   output wire logic comp_o // comparator output
);
   // fixed lag keeps transitions away from the sampling edge
   assign #DLY comp_o = level_i;
endmodule
`default_nettype wire

// ---- bebf_filter_assertions.sv ----
/* concurrent checks on the filter's ports.
   assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module bebf_filter_assertions (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic sample_tick_i,
   input wire logic commutate_i,
   input wire logic sim_demag_i,
   input wire logic sensor_mode_select_i,
   input wire logic demag_irq_clr_i,
   input wire logic demag_event_o,
   input wire logic zero_cross_event_o,
   input wire logic demag_irq_flag_o,
   input wire logic zero_cross_irq_flag_o,
   input wire logic demag_blank_o,
   input wire logic zero_cross_blank_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // commutation that must open the demag window
   sequence s_comm_sl;
      commutate_i && !sensor_mode_select_i;
   endsequence
   // demag event not overridden by a restart on its qualifying edge
   sequence s_d_clean;
      demag_event_o && !sensor_mode_select_i && !$past(commutate_i);
   endsequence
   AST_D_OPEN: assert property (s_comm_sl |=> demag_blank_o)
      else $error("demag window not opened");
   AST_D_NOWIN: assert property (commutate_i && sensor_mode_select_i |=> !demag_blank_o)
      else $error("demag window in sensor mode");
   AST_D_QUIET: assert property (demag_blank_o && !sim_demag_i && !commutate_i
      |=> !demag_event_o)
      else $error("demag event inside window");
   AST_Z_OPEN: assert property (s_d_clean |-> zero_cross_blank_o)
      else $error("zero-cross window not opened");
   AST_D_CAUSE: assert property (demag_event_o
      |-> $past(sample_tick_i) || $past(sim_demag_i))
      else $error("demag event without cause");
   AST_D_FLAG: assert property (demag_event_o |-> demag_irq_flag_o)
      else $error("demag flag not set");
   AST_Z_FLAG: assert property (zero_cross_event_o |-> zero_cross_irq_flag_o)
      else $error("zero-cross flag not set");
   AST_D_HOLD: assert property (demag_irq_flag_o && !demag_irq_clr_i |=> demag_irq_flag_o)
      else $error("demag flag lost");
endmodule
bind bebf_filter bebf_filter_assertions u_chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
   .sample_tick_i(sample_tick_i), .commutate_i(commutate_i), .sim_demag_i(sim_demag_i),
   .sensor_mode_select_i(sensor_mode_select_i), .demag_irq_clr_i(demag_irq_clr_i),
   .demag_event_o(demag_event_o), .zero_cross_event_o(zero_cross_event_o),
   .demag_irq_flag_o(demag_irq_flag_o), .zero_cross_irq_flag_o(zero_cross_irq_flag_o),
   .demag_blank_o(demag_blank_o), .zero_cross_blank_o(zero_cross_blank_o));
`default_nettype wire

// ---- testbench.sv ----
/* self-checking bench for the blanking and event filter.
   assumes the comparator stand-in and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic sys_clk_i = 0, resetn_i = 0, tick = 0, sens = 0, comparator_edge_select = 0, dm = 0;
   logic pz = 0, rel = 0, level = 0, dmsk = 1, zmsk = 1;
   // one strobe per pulsed input: commutation, sim d, sim z, d clear, z clear
   logic [4:0] pls = 5'h00;
   localparam int P_COMM = 0, P_SD = 1, P_SZ = 2, P_DCLR = 3, P_ZCLR = 4;
   logic [3:0] dwin = 0, dlim = 0, zwin = 0, zlim = 0;
   logic [31:0] r;
   wire comp, d_ev, z_ev, d_fl, z_fl, irq, d_bl, z_bl;
   int mismatches = 0, checked = 0, dbl_n = 0, zbl_n = 0, dev_n = 0, zev_n = 0, n, b0, b1;
   integer seed = 32'ha26e_aa81;
   always #20 sys_clk_i = ~sys_clk_i;
   // running totals; read before the edge's own updates land
   always @(posedge sys_clk_i) begin
      dbl_n += d_bl;
      zbl_n += z_bl;
      dev_n += d_ev;
      zev_n += z_ev;
   end
   bebf_phase_src src (.level_i(level), .comp_o(comp));
   bebf_filter DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .comp_i(comp),
      .sample_tick_i(tick), .commutate_i(pls[P_COMM]), .sim_demag_i(pls[P_SD]),
      .sim_zero_cross_i(pls[P_SZ]),
      .sensor_mode_select_i(sens), .edge_relation_select_i(rel),
      .comparator_edge_select_i(comparator_edge_select), .edge_protect_enable_i(pz),
      .demag_blank_len_i(dwin), .demag_count_limit_i(dlim), .zero_cross_blank_len_i(zwin),
      .zero_cross_count_limit_i(zlim), .demag_irq_mask_i(dmsk), .zero_cross_irq_mask_i(zmsk),
      .demag_irq_clr_i(pls[P_DCLR]), .zero_cross_irq_clr_i(pls[P_ZCLR]), .demag_event_o(d_ev),
      .zero_cross_event_o(z_ev), .demag_irq_flag_o(d_fl), .zero_cross_irq_flag_o(z_fl),
      .irq_o(irq), .demag_blank_o(d_bl), .zero_cross_blank_o(z_bl));
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
   endtask
   // one-cycle pulse, then a gap so pulses never merge
   task automatic pulse(input int b);
      pls[b] <= 1'b1;
      cyc(1);
      pls[b] <= 1'b0;
      cyc(1);
   endtask
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %0h got %0h", what, e, g);
      end
   endtask
   // window length in 25 MHz cycles for a code
   function automatic int win_cyc(input int c);
      return c < 8 ? 125 * (c + 1) : 25 * (60 + 20 * (c - 8));
   endfunction
   // up to k ticks, stopping once the event shows; 3 cycles let the synchroniser settle
   task automatic ticks(input bit z, input int k, output int n);
      int e0;
      e0 = z ? zev_n : dev_n;
      n = 0;
      cyc(3);
      while (n < k && e0 == (z ? zev_n : dev_n)) begin
         tick <= 1;
         cyc(1);
         tick <= 0;
         cyc(3);
         n++;
      end
   endtask
   task automatic final_report;
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      cyc(20);
      resetn_i <= 1;
      cyc(2);
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         comparator_edge_select <= r[0];
         level <= r[0];
         // relation bit left cleared in most passes, set in every fourth
         rel <= (i % 4 == 3);
         // d level: opposite of the z level unless the relation bit is set
         dm = (i % 4 == 3) ? r[0] : ~r[0];
         dlim <= r[7:4];
         dmsk <= r[8];
         zmsk <= r[9];
         dwin <= 4'(i);
         zwin <= 4'(15 - i);
         zlim <= 4'(i);
         b0 = dbl_n;
         pulse(P_COMM);
         cyc(win_cyc(i) + 4);
         cmp("demag_blank", win_cyc(i), dbl_n - b0);
         level <= dm;
         ticks(0, r[7:4], n);
         level <= ~dm;
         ticks(0, 1, n);
         level <= dm;
         b0 = zbl_n;
         ticks(0, 20, n);
         cmp("demag_ticks", r[7:4] + 1, n);
         cyc(win_cyc(15 - i) + 4);
         cmp("zc_blank", win_cyc(15 - i), zbl_n - b0);
         level <= r[0];
         ticks(1, 20, n);
         cmp("zc_ticks", i + 1, n);
         cmp("flags", {2'b11, r[8] | r[9]}, {d_fl, z_fl, irq});
         pulse(P_DCLR);
         pulse(P_ZCLR);
         cmp("cleared", 0, {d_fl, z_fl, irq});
      end
      // sensor mode, edge protection and simulated events
      sens <= 1;
      pz <= 1;
      rel <= 0;
      dlim <= 4'hf;
      zlim <= 4'hf;
      level <= ~comparator_edge_select;
      b0 = dbl_n;
      pulse(P_COMM);
      ticks(0, 20, n);
      cmp("sensor_ticks", 1, n);
      cmp("sensor_blank", 0, dbl_n - b0);
      level <= comparator_edge_select;
      ticks(1, 20, n);
      cmp("protect_ticks", 1, n);
      // a level already held at the previous tick is no transition: z stays quiet
      b0 = dev_n;
      b1 = zev_n;
      pulse(P_COMM);
      ticks(0, 1, n);
      pulse(P_SD);
      ticks(1, 2, n);
      cmp("protect_hold", 0, zev_n - b1);
      pulse(P_SZ);
      cyc(1);
      cmp("sim_events", 2, dev_n - b0 + zev_n - b1);
      final_report;
   end
   // hang guard well past the longest run
   initial begin
      cyc(95000);
      mismatches++;
      final_report;
   end
endmodule
`default_nettype wire
